// file: src/aof_pkg.sv
package aof_pkg;

	// register map, 16-bit registers on a plain port
	localparam logic [3:0]  ADDR_CONTROL = 4'h0; // filter_control
	localparam logic [3:0]  ADDR_RESULT  = 4'h1; // filter_result
	localparam logic [3:0]  ADDR_STATUS  = 4'h2; // sticky event status
	localparam logic [3:0]  ADDR_MASK    = 4'h3; // event mask

	// filter_control field positions
	localparam int BIT_ON      = 15;
	localparam int BIT_MODE_HI = 14;
	localparam int BIT_MODE_LO = 13;
	localparam int BIT_RAT_HI  = 12;
	localparam int BIT_RAT_LO  = 10;
	localparam int BIT_IE      = 9;
	localparam int BIT_RDY     = 8;
	localparam int BIT_SEL_HI  = 4;

	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] CONTROL_WMASK = 16'hFE1F; // ready is hw owned

	// filter modes
	localparam logic [1:0]  MODE_OVERSAMPLE = 2'h0;
	localparam logic [1:0]  MODE_AVERAGE    = 2'h3;

	// channel select codes
	localparam logic [4:0]  SEL_AN_LAST = 5'h0F;
	localparam logic [4:0]  SEL_TEMP    = 5'h10;
	localparam logic [4:0]  SEL_BANDGAP = 5'h11;

	// status bits
	localparam int ST_DONE = 0;

	// one converter result from the shared core
	typedef struct packed {
		logic        valid;
		logic [4:0]  channel;
		logic [11:0] data;
	} aof_sample_s;

	// register port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} aof_bus_s;

endpackage : aof_pkg

// file: src/aof_filter.sv
// How it works
// - select codes 0 to 15 feed analog inputs 0 to 15 into the filter.
// - code 16 feeds the temperature sensor and code 17 the band-gap.
// - mode 11 averages and always yields a 12-bit result.
// - mode 00 oversamples, widening the result except at 2x (12 bits), 16 bits at 256x only.
`timescale 1ns/1ps
`default_nettype none

module aof_filter
	import aof_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	// register port
	input  wire aof_bus_s    bus_i,
	output logic [15:0]      rdata_o,
	// converter results
	input  wire aof_sample_s sample_i,
	// interrupt
	output logic             irq_o
);

	typedef enum logic [1:0] {IDLE, ACCUM} aof_state_e;

	aof_state_e  state_q;
	logic [15:0] ctrl_q;
	logic [15:0] result_q;
	logic [8:0]  count_q;
	logic [19:0] acc_q;
	logic        status_q;
	logic        mask_q;
	logic        done;

	// samples per result for a ratio code
	function automatic logic [8:0] ratio_n(input logic [1:0] m,
		input logic [2:0] r);
		logic [8:0] n;
		n = 9'h000;
		if (m == MODE_AVERAGE)
			n = 9'h002 << r; // 2x..256x in code order
		else
			case (r)
				3'h0: n = 9'h004;
				3'h1: n = 9'h010;
				3'h2: n = 9'h040;
				3'h3: n = 9'h100;
				3'h4: n = 9'h002;
				3'h5: n = 9'h008;
				3'h6: n = 9'h020;
				default: n = 9'h080;
			endcase
		return n;
	endfunction

	// right shift applied to the sum to form the result
	function automatic logic [3:0] ratio_shift(input logic [1:0] m,
		input logic [2:0] r);
		logic [3:0] s;
		s = 4'h0;
		if (m == MODE_AVERAGE)
			s = 4'(r) + 4'h1;
		else
			case (r)
				3'h0, 3'h4: s = 4'h1; // 13-bit at code 0, 12-bit at code 4
				3'h1, 3'h5: s = 4'h2; // 14-bit at code 1, 13-bit at code 5
				3'h2, 3'h6: s = 4'h3; // 15-bit at code 2, 14-bit at code 6
				default:    s = 4'h4; // 16-bit at code 3, 15-bit at code 7
			endcase
		return s;
	endfunction

	// write strobe aimed at one register
	function automatic logic wr_hit(input aof_bus_s b,
		input logic [3:0] a);
		return b.wr && (b.addr == a);
	endfunction

	// read strobe aimed at one register
	function automatic logic rd_hit(input aof_bus_s b,
		input logic [3:0] a);
		return b.rd && (b.addr == a);
	endfunction

	wire logic       on   = ctrl_q[BIT_ON];
	wire logic [1:0] mode = ctrl_q[BIT_MODE_HI:BIT_MODE_LO];
	wire logic [2:0] rat  = ctrl_q[BIT_RAT_HI:BIT_RAT_LO];
	wire logic [4:0] sel  = ctrl_q[BIT_SEL_HI:0];
	// reserved modes and codes 10010..11111 never take a sample
	wire logic mode_ok = (mode == MODE_OVERSAMPLE) || (mode == MODE_AVERAGE);
	wire logic sel_ok  = (sel <= SEL_BANDGAP);
	wire logic take    = on && mode_ok && sel_ok && sample_i.valid
		&& (sample_i.channel == sel);
	// 20 bits hold 256 full-scale samples without overflow
	wire logic [19:0] sum = acc_q + 20'(sample_i.data);
	wire logic ctrl_wr = wr_hit(bus_i, ADDR_CONTROL);
	wire logic res_rd  = rd_hit(bus_i, ADDR_RESULT);

	// a control write restarts the run, so the sample beside it is dropped
	// and can neither finish a result nor raise ready
	assign done = (state_q == ACCUM) && take && !ctrl_wr
		&& (count_q + 9'h001 == ratio_n(mode, rat));

	// accumulation sequencer
	// any reconfigure drops the partial sum and starts over
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_q <= IDLE;
			count_q <= 9'h000;
			acc_q   <= 20'h00000;
		end
		else
		begin
			case (state_q)
				IDLE:
				begin
					// entry cycle takes no sample; counters start from zero
					count_q <= 9'h000;
					acc_q   <= 20'h00000;
					if (on && mode_ok)
						state_q <= ACCUM;
				end
				ACCUM:
				begin
					if (!on || !mode_ok || ctrl_wr)
					begin
						state_q <= IDLE; // restart on reconfigure
					end
					else if (done)
					begin
						count_q <= 9'h000;
						acc_q   <= 20'h00000;
					end
					else if (take)
					begin
						count_q <= count_q + 9'h001;
						acc_q   <= sum;
					end
				end
				default: state_q <= IDLE;
			endcase
		end
	end

	// result register, scaled by mode and ratio
	// oversampled sums land as 12 to 16 bits, averages as 12 bits
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			result_q <= 16'h0000;
		else if (done)
			result_q <= 16'(sum >> ratio_shift(mode, rat));
	end

	// control register with hardware ready flag
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			ctrl_q <= CONTROL_RESET;
		else
		begin
			if (ctrl_wr)
				ctrl_q <= (bus_i.wdata & CONTROL_WMASK)
					| (ctrl_q & ~CONTROL_WMASK);
			// set wins: a result landing beside a read keeps ready high
			if (done)
				ctrl_q[BIT_RDY] <= 1'b1;
			else if (res_rd || !on || (ctrl_wr && !bus_i.wdata[BIT_ON]))
				ctrl_q[BIT_RDY] <= 1'b0;
		end
	end

	// sticky status, write one to clear, set wins; mask written directly
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			status_q <= 1'b0;
			mask_q   <= 1'b0;
		end
		else
		begin
			if (done && ctrl_q[BIT_IE])
				status_q <= 1'b1;
			else if (wr_hit(bus_i, ADDR_STATUS) && bus_i.wdata[ST_DONE])
				status_q <= 1'b0;
			if (wr_hit(bus_i, ADDR_MASK))
				mask_q <= bus_i.wdata[ST_DONE];
		end
	end

	// interrupt output
	// a flop so the pin never glitches; it lags status by one cycle
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= status_q & mask_q;
	end

	// read data, one cycle after the strobe
	// control bits 7 to 5 are never written, so they read back as zero
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rdata_o <= 16'h0000;
		else if (bus_i.rd)
			case (bus_i.addr)
				ADDR_CONTROL: rdata_o <= ctrl_q;
				ADDR_RESULT:  rdata_o <= result_q;
				ADDR_STATUS:  rdata_o <= {15'h0000, status_q};
				ADDR_MASK:    rdata_o <= {15'h0000, mask_q};
				default:      rdata_o <= 16'h0000;
			endcase
		else
			rdata_o <= 16'h0000;
	end

endmodule // aof_filter

`default_nettype wire

// file: tb/aof_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module aof_monitor
	import aof_pkg::*;
(
	// watched ports
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	input wire aof_bus_s    bus_i,
	input wire logic [15:0] rdata_o,
	input wire aof_sample_s sample_i,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// read port relations
	property p_quiet; !bus_i.rd |=> rdata_o == 16'h0000; endproperty
	a_quiet: assert property (p_quiet) else $error("idle read data");
	property p_ctl;
		bus_i.rd && bus_i.addr == ADDR_CONTROL |=> rdata_o[7:5] == 3'h0;
	endproperty
	a_ctl: assert property (p_ctl) else $error("gap bits set");
	property p_gap;
		bus_i.rd && bus_i.addr > ADDR_MASK |=> rdata_o == 16'h0000;
	endproperty
	a_gap: assert property (p_gap) else $error("unmapped read");
	// interrupt and ready relations
	property p_mask;
		bus_i.wr && bus_i.addr == ADDR_MASK && !bus_i.wdata[0] |=> ##1 !irq_o;
	endproperty
	a_mask: assert property (p_mask) else $error("masked irq");
	property p_off;
		bus_i.wr && bus_i.addr == ADDR_CONTROL && !bus_i.wdata[BIT_ON]
		##1 bus_i.rd && bus_i.addr == ADDR_CONTROL |=> !rdata_o[BIT_RDY];
	endproperty
	a_off: assert property (p_off) else $error("ready kept");
	// main scenarios
	c_irq: cover property ($rose(irq_o));
	c_smp: cover property (sample_i.valid);
	c_off: cover property (bus_i.wr && !bus_i.wdata[BIT_ON]);
endmodule // aof_monitor
`default_nettype wire

// file: tb/aof_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module aof_adc_model
	import aof_pkg::*;
(
	input  wire logic  clk_i,
	output var aof_sample_s sample_o
);
	initial sample_o = '0;
	// one result strobe, then junk on the idle bus
	task automatic send(input logic [4:0] ch, input logic [11:0] d);
		@(posedge clk_i);
		sample_o <= '{1'b1, ch, d};
		@(posedge clk_i);
		sample_o <= '{1'b0, ~ch, ~d};
	endtask
endmodule // aof_adc_model
`default_nettype wire

// file: tb/adc_oversampling_filter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_oversampling_filter_tb
	import aof_pkg::*;
;
	logic        clk_i;
	logic        arst_n_i;
	aof_bus_s    bus_i;
	logic [15:0] rdata_o;
	aof_sample_s sample_i;
	logic        irq_o;
	int          err_count;
	int          total_checks;
	aof_filter dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_i(bus_i),
		.rdata_o(rdata_o), .sample_i(sample_i), .irq_o(irq_o));
	aof_adc_model adc_u (.clk_i(clk_i), .sample_o(sample_i));
	always #5 clk_i = ~clk_i;
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		bus_i <= '{1'b1, 1'b0, a, d};
		@(posedge clk_i);
		bus_i <= '0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_i);
		bus_i <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk_i);
		bus_i <= '0;
		#1 chk(rdata_o, e);
	endtask
	// one filtered result: stray channel, n samples, irq, read, clear
	task automatic run(input logic [15:0] c, input int n,
		input logic [11:0] v, input logic [15:0] e);
		int i;
		wr(ADDR_CONTROL, c);
		repeat (2) @(posedge clk_i);
		adc_u.send(c[4:0] ^ 5'h01, 12'h000);
		for (i = 0; i < n; i++)
			adc_u.send(c[4:0], v);
		// poll on the falling edge, where the flopped pin has settled
		for (i = 0; irq_o !== 1'b1 && i < 50; i++)
			@(negedge clk_i);
		chk({15'h0000, irq_o}, 16'h0001);
		if (i == 50)
			end_sim();
		rd(ADDR_CONTROL, c | 16'h0100);
		rd(ADDR_STATUS, 16'h0001);
		rd(ADDR_RESULT, e);
		rd(ADDR_CONTROL, c);
		wr(ADDR_STATUS, 16'h0001);
		rd(ADDR_STATUS, 16'h0000);
		chk({15'h0000, irq_o}, 16'h0000);
	endtask
	// irq enable off: ready alone reports, then disable drops ready
	task automatic quiet_off();
		int i;
		wr(ADDR_CONTROL, 16'hE003);
		repeat (2) @(posedge clk_i);
		for (i = 0; i < 2; i++)
			adc_u.send(5'h03, 12'h456);
		repeat (2) @(posedge clk_i);
		rd(ADDR_CONTROL, 16'hE103);
		rd(ADDR_STATUS, 16'h0000);
		chk({15'h0000, irq_o}, 16'h0000);
		@(posedge clk_i);
		bus_i <= '{1'b1, 1'b0, ADDR_CONTROL, 16'h0000};
		@(posedge clk_i);
		bus_i <= '{1'b0, 1'b1, ADDR_CONTROL, 16'h0000};
		@(posedge clk_i);
		bus_i <= '0;
		#1 chk(rdata_o, 16'h0000);
		rd(ADDR_RESULT, 16'h0456);
	endtask
	initial
	begin
		clk_i = 1'b0;
		arst_n_i = 1'b0;
		bus_i = '0;
		err_count = 0;
		total_checks = 0;
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rd(ADDR_CONTROL, CONTROL_RESET);
		rd(4'h9, 16'h0000);
		wr(ADDR_CONTROL, 16'hFFEF);
		rd(ADDR_CONTROL, 16'hFE0F);
		wr(ADDR_MASK, 16'h0001);
		rd(ADDR_MASK, 16'h0001);
		run(16'hFE10, 256, 12'hABC, 16'h0ABC);
		run(16'h8211, 4, 12'hFFF, 16'h1FFE);
		run(16'h8E0F, 256, 12'hFFF, 16'hFFF0);
		run(16'hE203, 2, 12'h123, 16'h0123);
		quiet_off();
		wr(ADDR_MASK, 16'h0000);
		rd(ADDR_MASK, 16'h0000);
		end_sim();
	end
endmodule // adc_oversampling_filter_tb
bind aof_filter aof_monitor mon_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
	.bus_i(bus_i), .rdata_o(rdata_o), .sample_i(sample_i), .irq_o(irq_o));
`default_nettype wire
